// [core/osc_trim_cal.sv]
/*
 * Oscillator trim calibration: counter comparison of the low-power oscillator
 * against the precision oscillator, and automatic trim stepping from LIN
 * baud measurements. Assumes oscillator clocks arrive as pins and that the
 * baud value and its valid pulse come from logic on CLOCK.
 */
`timescale 1ns/10ps
`include "osc_trim_params.svh"
module osc_trim_cal (
    input  wire logic                  CLOCK,
    input  wire logic                  ARST_N,
    input  wire osc_trim_pkg::bus_req_t BUS_REQ,
    output logic [31:0]                RDATA,
    input  wire logic                  LP_OSC_CLK,
    input  wire logic                  PREC_OSC_CLK,
    input  wire logic [15:0]           BAUD_VALUE,
    input  wire logic                  BAUD_VALID,
    output osc_trim_pkg::trim_out_t    TRIM
);
    import osc_trim_pkg::*;

    cal_ctrl_t   cc_r;
    cal_state_t  state_r;
    cal_state_t  state_nxt;
    logic        complete_r;
    logic        finished_r;
    logic        meas_ovf_r;
    logic [8:0]  ref_count;
    logic [9:0]  meas_count;
    logic        meas_carry;
    lin_ctrl_t   lc_r;
    logic        sel_lp_r;
    logic        armed_r;
    logic [7:0]  lp_user_r;
    logic [9:0]  prec_user_r;
    logic [7:0]  lp_cur_r;
    logic [9:0]  prec_cur_r;
    logic [15:0] upper_r;
    logic [15:0] lower_r;
    logic        lp_mod_r;
    logic        prec_mod_r;
    logic [31:0] rdata_r;

    // Address decode
    wire logic hit_cc    = BUS_REQ.addr == `ADDR_CAL_CONTROL;
    wire logic hit_sta   = BUS_REQ.addr == `ADDR_CAL_STATUS;
    wire logic hit_ref   = BUS_REQ.addr == `ADDR_REFERENCE_COUNT;
    wire logic hit_meas  = BUS_REQ.addr == `ADDR_MEASURED_COUNT;
    wire logic hit_lc    = BUS_REQ.addr == `ADDR_LIN_CAL_CONTROL;
    wire logic hit_lpu   = BUS_REQ.addr == `ADDR_LP_USER_TRIM;
    wire logic hit_pru   = BUS_REQ.addr == `ADDR_PREC_USER_TRIM;
    wire logic hit_up    = BUS_REQ.addr == `ADDR_BAUD_UPPER;
    wire logic hit_lo    = BUS_REQ.addr == `ADDR_BAUD_LOWER;
    wire logic hit_lsta  = BUS_REQ.addr == `ADDR_LIN_CAL_STATUS;
    wire logic hit_lpc   = BUS_REQ.addr == `ADDR_LP_CURRENT_TRIM;
    wire logic hit_prc   = BUS_REQ.addr == `ADDR_PREC_CURRENT_TRIM;
    wire logic hit_key   = BUS_REQ.addr == `ADDR_UNLOCK_KEY;
    wire logic hit_sel   = BUS_REQ.addr == `ADDR_LIN_CAL_SELECT;

    // Protected writes pass only after a key write; the next protected write disarms
    wire logic prot_hit  = hit_lc || hit_lpu || hit_pru;
    wire logic wr_cc     = BUS_REQ.wr && hit_cc;
    wire logic wr_lc     = BUS_REQ.wr && hit_lc && armed_r;
    wire logic wr_lpu    = BUS_REQ.wr && hit_lpu && armed_r;
    wire logic wr_pru    = BUS_REQ.wr && hit_pru && armed_r;
    wire logic wr_key    = BUS_REQ.wr && hit_key;

    // Read side effects
    wire logic rd_sta    = BUS_REQ.rd && hit_sta;
    wire logic rd_meas   = BUS_REQ.rd && hit_meas;
    wire logic rd_lsta   = BUS_REQ.rd && hit_lsta;

    // Counter calibration sequencing
    wire logic busy      = state_r == CAL_RUN;
    wire logic hold_rst  = cc_r.cal_reset;
    wire logic start     = wr_cc && BUS_REQ.wdata[0] && !BUS_REQ.wdata[3]
                           && !cc_r.cal_enable;
    wire logic ref_done  = busy && ref_count == `REF_TERMINAL;
    wire logic abort     = busy && (!cc_r.cal_enable || hold_rst);
    wire logic count_en  = busy && !ref_done && !hold_rst;
    wire logic busy_fall = busy && state_nxt == CAL_IDLE;
    wire logic ref_clear = hold_rst || cc_r.ref_clr;
    wire logic meas_clear = hold_rst || cc_r.meas_clr;

    // Run state: start from idle, end on terminal count or abort
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            CAL_IDLE: begin
                if (start) begin
                    state_nxt = CAL_RUN;
                end
            end
            CAL_RUN: begin
                if (ref_done || abort) begin
                    state_nxt = CAL_IDLE;
                end
            end
            default: begin
                state_nxt = CAL_IDLE;
            end
        endcase
    end

    // Control register, run state and status flags; a set wins over a clear, except for the overflow flag, where the clear wins
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            cc_r       <= cal_ctrl_t'(`CAL_CONTROL_RESET);
            state_r    <= CAL_IDLE;
            complete_r <= 1'b0;
            finished_r <= 1'b0;
            meas_ovf_r <= 1'b0;
        end else begin
            if (wr_cc) begin
                cc_r <= cal_ctrl_t'({4'h0, BUS_REQ.wdata[3:0]});
            end
            state_r    <= state_nxt;
            complete_r <= ref_done || (complete_r && !rd_meas);
            finished_r <= busy_fall || (finished_r && !rd_sta);
            meas_ovf_r <= !meas_clear && (meas_carry || meas_ovf_r);
        end
    end

    // Reference counter on the precision oscillator
    osc_edge_counter #(
        .W(9)
    ) u_ref_cnt (
        .clk      (CLOCK),
        .arst_n   (ARST_N),
        .osc_pin  (PREC_OSC_CLK),
        .clear    (ref_clear),
        .count_en (count_en),
        .count    (ref_count),
        .carry    ()
    );

    // Measured counter on the low-power oscillator
    osc_edge_counter #(
        .W(10)
    ) u_meas_cnt (
        .clk      (CLOCK),
        .arst_n   (ARST_N),
        .osc_pin  (LP_OSC_CLK),
        .clear    (meas_clear),
        .count_en (count_en),
        .count    (meas_count),
        .carry    (meas_carry)
    );

    // Trim stepping from the sync-field baud measurement
    wire logic [2:0] step   = {1'b0, lc_r.step_code} + 3'h1;
    wire logic       too_hi = BAUD_VALID && lc_r.lin_enable && BAUD_VALUE > upper_r;
    wire logic       too_lo = BAUD_VALID && lc_r.lin_enable && BAUD_VALUE < lower_r;
    wire logic       adj_lp = (too_hi || too_lo) && sel_lp_r;
    wire logic       adj_pr = (too_hi || too_lo) && !sel_lp_r;
    wire logic [8:0] lp_sum = {1'b0, lp_cur_r} + {6'h00, step};
    wire logic [10:0] pr_sum = {1'b0, prec_cur_r} + {8'h00, step};

    // Fast oscillator gives a high baud count: raise trim to slow it
    wire logic [7:0] lp_up  = lp_sum[8] ? 8'hFF : lp_sum[7:0];
    wire logic [7:0] lp_dn  = (lp_cur_r < {5'h00, step}) ? 8'h00 : lp_cur_r - {5'h00, step};
    wire logic [9:0] pr_up  = pr_sum[10] ? 10'h3FF : pr_sum[9:0];
    wire logic [9:0] pr_dn  = (prec_cur_r < {7'h00, step}) ? 10'h000
                              : prec_cur_r - {7'h00, step};
    wire logic [7:0] lp_adj = too_hi ? lp_up : lp_dn;
    wire logic [9:0] pr_adj = too_hi ? pr_up : pr_dn;
    wire logic       lp_chg = adj_lp && lp_adj != lp_cur_r;
    wire logic       pr_chg = adj_pr && pr_adj != prec_cur_r;

    // LIN registers and key
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            lc_r        <= lin_ctrl_t'(`LIN_CTRL_RESET);
            sel_lp_r    <= `LIN_SELECT_RESET;
            armed_r     <= 1'b0;
            lp_user_r   <= `LP_TRIM_RESET;
            prec_user_r <= `PREC_TRIM_RESET;
            upper_r     <= `LIMIT_RESET;
            lower_r     <= `LIMIT_RESET;
        end else begin
            if (wr_key) begin
                armed_r <= BUS_REQ.wdata[15:0] == `UNLOCK_KEY_VALUE;
            end else if (BUS_REQ.wr && prot_hit) begin
                armed_r <= 1'b0;
            end
            if (wr_lc) begin
                lc_r <= lin_ctrl_t'({5'h00, BUS_REQ.wdata[2:0]});
            end
            if (wr_lpu) begin
                lp_user_r <= BUS_REQ.wdata[7:0];
            end
            if (wr_pru) begin
                prec_user_r <= BUS_REQ.wdata[9:0];
            end
            if (BUS_REQ.wr && hit_up) begin
                upper_r <= BUS_REQ.wdata[15:0];
            end
            if (BUS_REQ.wr && hit_lo) begin
                lower_r <= BUS_REQ.wdata[15:0];
            end
            if (BUS_REQ.wr && hit_sel) begin
                sel_lp_r <= BUS_REQ.wdata[0];
            end
        end
    end

    // Current trims follow user writes, else automatic steps
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            lp_cur_r   <= `LP_TRIM_RESET;
            prec_cur_r <= `PREC_TRIM_RESET;
            lp_mod_r   <= 1'b0;
            prec_mod_r <= 1'b0;
        end else begin
            lp_cur_r   <= wr_lpu ? BUS_REQ.wdata[7:0] : adj_lp ? lp_adj : lp_cur_r;
            prec_cur_r <= wr_pru ? BUS_REQ.wdata[9:0] : adj_pr ? pr_adj : prec_cur_r;
            lp_mod_r   <= lp_chg || (lp_mod_r && !rd_lsta);
            prec_mod_r <= pr_chg || (prec_mod_r && !rd_lsta);
        end
    end

    // Read selection; unmapped addresses read zero
    wire logic [7:0] sta_val  = {5'h00, complete_r, busy, finished_r};
    wire logic [7:0] lsta_val = {5'h00, lp_mod_r, prec_mod_r, sel_lp_r};
    wire logic [31:0] rd_val  =
        hit_cc   ? {24'h00_0000, cc_r} :
        hit_sta  ? {24'h00_0000, sta_val} :
        hit_ref  ? {23'h00_0000, ref_count} :
        hit_meas ? {21'h00_0000, meas_ovf_r, meas_count} :
        hit_lc   ? {24'h00_0000, lc_r} :
        hit_lpu  ? {24'h00_0000, lp_user_r} :
        hit_pru  ? {22'h00_0000, prec_user_r} :
        hit_up   ? {16'h0000, upper_r} :
        hit_lo   ? {16'h0000, lower_r} :
        hit_lsta ? {24'h00_0000, lsta_val} :
        hit_lpc  ? {24'h00_0000, lp_cur_r} :
        hit_prc  ? {22'h00_0000, prec_cur_r} :
        hit_sel  ? {31'h0000_0000, sel_lp_r} : 32'h0000_0000;

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= BUS_REQ.rd ? rd_val : 32'h0000_0000;
        end
    end

    assign RDATA     = rdata_r;
    assign TRIM      = '{lp: lp_cur_r, prec: prec_cur_r};

    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);

    a_start_runs: assert property (start |=> busy ##1 (busy || !cc_r.cal_enable || ref_done
        || hold_rst)) else $error("start did not enter run");
    a_abort_stops: assert property (busy && !cc_r.cal_enable |=> !busy)
        else $error("abort did not stop run");
    a_reset_holds: assert property (hold_rst ##1 hold_rst |-> ref_count == 9'h000
        && meas_count == 10'h000 && !busy) else $error("calibration reset not held");
    a_ref_clears: assert property (cc_r.ref_clr |=> ref_count == 9'h000)
        else $error("reference counter not cleared");
    a_meas_clears: assert property (cc_r.meas_clr |=> meas_count == 10'h000 && !meas_ovf_r)
        else $error("measured counter not cleared");
    a_terminal_stop: assert property (busy && ref_count == 9'h1FF && !ref_clear && !meas_clear
        |=> !busy && ref_count == 9'h1FF && $stable(meas_count))
        else $error("terminal count did not stop");
    a_complete_flag: assert property (ref_done |=> complete_r [*2] or
        (complete_r ##1 $past(rd_meas))) else $error("complete flag missing");
    a_finish_flag: assert property ($fell(busy) |-> finished_r)
        else $error("finished flag missing after busy fell");
    a_finish_clear: assert property (rd_sta && !busy_fall |=> !finished_r)
        else $error("finished flag not cleared by read");
    a_locked_write: assert property (BUS_REQ.wr && hit_lc && !armed_r |=> $stable(lc_r))
        else $error("locked control accepted a write");
    a_user_kept: assert property (adj_lp && !wr_lpu |=> $stable(lp_user_r))
        else $error("user trim changed by auto trim");
    a_step_up: assert property (adj_lp && too_hi && lp_cur_r < 8'hF0 && !wr_lpu
        |=> lp_cur_r == $past(lp_cur_r) + 8'($past(step)) && lp_mod_r)
        else $error("low-power trim step wrong");
    a_step_down: assert property (adj_pr && too_lo && prec_cur_r > 10'h010 && !wr_pru
        |=> prec_cur_r == $past(prec_cur_r) - 10'($past(step)) && prec_mod_r)
        else $error("precision trim step wrong");
    a_mod_clear: assert property (rd_lsta && !lp_chg |=> !lp_mod_r)
        else $error("modified flag not cleared by read");

    c_cal_done: cover property (busy ##1 ref_done ##1 !busy);
    c_cal_abort: cover property (busy && !cc_r.cal_enable);
    c_lp_step: cover property (lp_chg);
    c_prec_step: cover property (pr_chg);

endmodule

// [core/osc_trim_params.svh]
/*
 * Addresses, field positions, reset values and fixed codes of the oscillator
 * trim calibration block. Definitions only; included by the calibration module
 * and the bench, which expect 32-bit byte addresses on the register port.
 */
// Operation
// - Calibration-reset bit holds both counters cleared and stops the calibration.
// - Control bit 2 clears the low-power measured counter.
// - Control bit 1 clears the precision reference counter.
// - Control bit 0 set starts a run; cleared it aborts the run.
// - Complete bit sets on full completion, clears on measured counter read.
// - Busy bit stands high while a calibration runs.
// - Finished flag sets when busy falls, clears on status read.
// - Reference counter is 9 bits, precision clocked, read only.
// - Measured counter counts 10 bits on low-power clock, reads 11 bits.
// - Reference counter at terminal count stops both counters, ending the run.
// - LIN trimming works from one fixed baud rate sync measurement.
// - Baud value outside limits steps the selected trim in correcting direction.
// - LIN trimming changes only current trims, never user trims.
// - A status register shows whether selected oscillator trim was altered.
// - Step field bits 2:1 codes 0 to 3 give steps 1 to 4.
// - LIN control bit 0 enables automatic trimming.
// - Trim-modified flags set on change, clear on LIN status read.
// - LIN status bit 0 high selects low-power, low selects precision oscillator.
`ifndef OSC_TRIM_PARAMS_SVH
`define OSC_TRIM_PARAMS_SVH

// Register byte addresses
`define ADDR_CAL_CONTROL      32'hFFFF_0440
`define ADDR_CAL_STATUS       32'hFFFF_0444
`define ADDR_REFERENCE_COUNT  32'hFFFF_0448
`define ADDR_MEASURED_COUNT   32'hFFFF_044C
`define ADDR_LIN_CAL_CONTROL  32'hFFFF_0480
`define ADDR_LP_USER_TRIM     32'hFFFF_0484
`define ADDR_PREC_USER_TRIM   32'hFFFF_0488
`define ADDR_BAUD_UPPER       32'hFFFF_048C
`define ADDR_BAUD_LOWER       32'hFFFF_0490
`define ADDR_LIN_CAL_STATUS   32'hFFFF_0494
`define ADDR_LP_CURRENT_TRIM  32'hFFFF_0498
`define ADDR_PREC_CURRENT_TRIM 32'hFFFF_049C
`define ADDR_UNLOCK_KEY       32'hFFFF_04A0
`define ADDR_LIN_CAL_SELECT   32'hFFFF_04A4

// Reset values and codes
`define CAL_CONTROL_RESET     8'h00
`define LIN_CTRL_RESET        8'h00
`define LIN_SELECT_RESET      1'h1
`define LP_TRIM_RESET         8'h80
`define PREC_TRIM_RESET       10'h200
`define LIMIT_RESET           16'h0000
`define UNLOCK_KEY_VALUE      16'h1324
`define REF_TERMINAL          9'h1FF

// Status field positions
`define STA_COMPLETE_BIT      2
`define STA_BUSY_BIT          1
`define STA_FINISHED_BIT      0
`define LSTA_LP_MOD_BIT       2
`define LSTA_PREC_MOD_BIT     1
`define LSTA_SELECT_BIT       0

`endif

// [core/osc_trim_pkg.sv]
/*
 * Types of the oscillator trim calibration block: register layouts, bus
 * request carrier, trim output carrier and calibration states.
 */
package osc_trim_pkg;

    // Counter calibration control layout
    typedef struct packed {
        logic [3:0] unused;
        logic       cal_reset;
        logic       meas_clr;
        logic       ref_clr;
        logic       cal_enable;
    } cal_ctrl_t;

    // LIN calibration control layout
    typedef struct packed {
        logic [4:0] unused;
        logic [1:0] step_code;
        logic       lin_enable;
    } lin_ctrl_t;

    // Register port request
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    // Trim words driven to the two oscillators
    typedef struct packed {
        logic [7:0] lp;
        logic [9:0] prec;
    } trim_out_t;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN  = 2'b01
    } cal_state_t;

endpackage

// [core/osc_edge_counter.sv]
/*
 * Counts rising edges of an oscillator pin in the system clock domain.
 * Assumes the system clock is far faster than the oscillator pin.
 */
`timescale 1ns/10ps
module osc_edge_counter #(
    parameter int unsigned W = 9
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         osc_pin,
    input  wire logic         clear,
    input  wire logic         count_en,
    output logic [W-1:0]      count,
    output logic              carry
);

    logic         sync1_r;
    logic         sync2_r;
    logic         hist_r;
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    wire  logic   osc_edge;

    // Two-stage synchroniser, then a history stage for the edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            hist_r  <= 1'b0;
        end else begin
            sync1_r <= osc_pin;
            sync2_r <= sync1_r;
            hist_r  <= sync2_r;
        end
    end

    // Clear wins over counting
    assign osc_edge  = sync2_r && !hist_r;
    assign count_nxt = clear ? '0 : (osc_edge && count_en) ? count_r + 1'b1 : count_r;
    assign carry     = !clear && osc_edge && count_en && (&count_r);
    assign count     = count_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule

// [tb/osc_far_side.sv]
/*
 * Far side model: the two oscillator pins and the LIN baud measurement.
 * Assumes it shares CLOCK with the block and is driven by the bench tasks.
 */
`timescale 1ns/10ps
module osc_far_side #(
    parameter int LP_HALF   = 3,
    parameter int PREC_HALF = 2
) (
    input  wire logic   clk,
    input  wire logic   arst_n,
    output logic        lp_pin,
    output logic        prec_pin,
    output logic [15:0] baud_value,
    output logic        baud_valid
);
    int lp_cnt;
    int prec_cnt;

    initial begin
        baud_value = 16'h0000;
        baud_valid = 1'b0;
    end

    // Free running oscillators, a fixed count of clocks per half period
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lp_cnt   <= 0;
            prec_cnt <= 0;
            lp_pin   <= 1'b0;
            prec_pin <= 1'b0;
        end else begin
            lp_cnt   <= (lp_cnt == LP_HALF - 1) ? 0 : lp_cnt + 1;
            prec_cnt <= (prec_cnt == PREC_HALF - 1) ? 0 : prec_cnt + 1;
            if (lp_cnt == LP_HALF - 1) lp_pin <= ~lp_pin;
            if (prec_cnt == PREC_HALF - 1) prec_pin <= ~prec_pin;
        end
    end

    // One sync field measurement at the fixed rate; value scrambled after
    task automatic send_baud(input logic [15:0] v);
        @(posedge clk);
        baud_value <= v;
        baud_valid <= 1'b1;
        @(posedge clk);
        baud_valid <= 1'b0;
        baud_value <= ~v;
    endtask
endmodule

// [tb/osc_trim_cal_tb.sv]
/*
 * Self-checking bench of the oscillator trim calibration block.
 * Assumes the register port answers one cycle after a read strobe.
 */
`timescale 1ns/10ps
`include "osc_trim_params.svh"
module osc_trim_cal_tb;
    import osc_trim_pkg::*;

    logic      clock;
    logic      arst_n;
    bus_req_t  req;
    logic [31:0] rdata;
    trim_out_t trim;
    logic      lp_pin;
    logic      prec_pin;
    logic [15:0] baud_value;
    logic      baud_valid;
    int        miscompares;
    int        cmp_count;
    int        cycles;
    int        n;
    logic [31:0] d;
    logic [7:0]  lp_exp;

    osc_trim_cal osc_trim_cal_i (
        .CLOCK        (clock),
        .ARST_N       (arst_n),
        .BUS_REQ      (req),
        .RDATA        (rdata),
        .LP_OSC_CLK   (lp_pin),
        .PREC_OSC_CLK (prec_pin),
        .BAUD_VALUE   (baud_value),
        .BAUD_VALID   (baud_valid),
        .TRIM         (trim)
    );

    osc_far_side osc_far_side_i (
        .clk        (clock),
        .arst_n     (arst_n),
        .lp_pin     (lp_pin),
        .prec_pin   (prec_pin),
        .baud_value (baud_value),
        .baud_valid (baud_valid)
    );

    // Clock and cycle ceiling
    initial clock = 1'b0;
    always #2 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clock);
        req.addr  <= a;
        req.wdata <= v;
        req.wr    <= 1'b1;
        @(posedge clock);
        req.wr    <= 1'b0;
    endtask

    task automatic bus_rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge clock);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clock);
        req.rd   <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus_rd(a, v);
        chk(what, exp, v);
    endtask

    task automatic keyed_wr(input logic [31:0] a, input logic [31:0] v);
        bus_wr(`ADDR_UNLOCK_KEY, {16'h0000, `UNLOCK_KEY_VALUE});
        bus_wr(a, v);
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        req = '0;
        miscompares = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        // Reset values and an unmapped place
        rd_chk("cal_control", `ADDR_CAL_CONTROL, 32'h0000_0000);
        rd_chk("cal_status", `ADDR_CAL_STATUS, 32'h0000_0000);
        rd_chk("reference_count", `ADDR_REFERENCE_COUNT, 32'h0000_0000);
        rd_chk("measured_count", `ADDR_MEASURED_COUNT, 32'h0000_0000);
        rd_chk("lin_cal_control", `ADDR_LIN_CAL_CONTROL, 32'h0000_0000);
        rd_chk("lin_cal_status", `ADDR_LIN_CAL_STATUS, 32'h0000_0001);
        rd_chk("unmapped", 32'hFFFF_04A8, 32'h0000_0000);
        chk("trim", {14'h0000, 18'h2_0200}, {14'h0000, trim});
        $display("Test reset values done");

        // Full run: reference reaches terminal count and both stop
        bus_wr(`ADDR_CAL_CONTROL, 32'h0000_0001);
        rd_chk("busy", `ADDR_CAL_STATUS, 32'h0000_0002);
        n = 0;
        do begin
            bus_rd(`ADDR_CAL_STATUS, d);
            n++;
        end while (d[1] !== 1'b0 && n < 1500);
        chk("end status", 32'h0000_0005, d);
        rd_chk("status reread", `ADDR_CAL_STATUS, 32'h0000_0004);
        bus_wr(`ADDR_REFERENCE_COUNT, 32'h0000_0055);
        repeat (30) @(posedge clock);
        rd_chk("reference_count", `ADDR_REFERENCE_COUNT, 32'h0000_01FF);
        bus_rd(`ADDR_MEASURED_COUNT, d);
        cmp_count++;
        if (d < 32'd336 || d > 32'd345) begin
            miscompares++;
            $display("BAD measured_count expected 336..345 seen %0d", d);
        end
        rd_chk("status after read", `ADDR_CAL_STATUS, 32'h0000_0000);
        $display("Test full run done");

        // Abort, then the two separate counter clears; counters cleared before the start
        bus_wr(`ADDR_CAL_CONTROL, 32'h0000_0006);
        bus_wr(`ADDR_CAL_CONTROL, 32'h0000_0001);
        repeat (40) @(posedge clock);
        bus_wr(`ADDR_CAL_CONTROL, 32'h0000_0000);
        rd_chk("abort status", `ADDR_CAL_STATUS, 32'h0000_0001);
        bus_wr(`ADDR_CAL_CONTROL, 32'h0000_0004);
        bus_wr(`ADDR_CAL_CONTROL, 32'h0000_0000);
        rd_chk("measured cleared", `ADDR_MEASURED_COUNT, 32'h0000_0000);
        bus_rd(`ADDR_REFERENCE_COUNT, d);
        chk("reference kept", 32'h0000_0001, {31'h0, d != 32'h0});
        bus_wr(`ADDR_CAL_CONTROL, 32'h0000_0002);
        bus_wr(`ADDR_CAL_CONTROL, 32'h0000_0000);
        rd_chk("reference cleared", `ADDR_REFERENCE_COUNT, 32'h0000_0000);
        // Calibration reset during a run
        bus_wr(`ADDR_CAL_CONTROL, 32'h0000_0001);
        repeat (40) @(posedge clock);
        bus_wr(`ADDR_CAL_CONTROL, 32'h0000_0009);
        repeat (10) @(posedge clock);
        rd_chk("reset reference", `ADDR_REFERENCE_COUNT, 32'h0000_0000);
        rd_chk("reset measured", `ADDR_MEASURED_COUNT, 32'h0000_0000);
        bus_rd(`ADDR_CAL_STATUS, d);
        chk("reset busy", 32'h0000_0000, {31'h0, d[1]});
        bus_wr(`ADDR_CAL_CONTROL, 32'h0000_0000);
        // Measured counter wraps while the reference is held cleared
        bus_wr(`ADDR_CAL_CONTROL, 32'h0000_0003);
        repeat (6400) @(posedge clock);
        bus_rd(`ADDR_MEASURED_COUNT, d);
        chk("measured wrap", 32'h0000_0001, {31'h0, d[10]});
        bus_wr(`ADDR_CAL_CONTROL, 32'h0000_0004);
        bus_wr(`ADDR_CAL_CONTROL, 32'h0000_0000);
        rd_chk("wrap cleared", `ADDR_MEASURED_COUNT, 32'h0000_0000);
        $display("Test abort and clears done");

        // LIN trimming: raise, then every step code lowering
        bus_wr(`ADDR_BAUD_UPPER, 32'h0000_0100);
        bus_wr(`ADDR_BAUD_LOWER, 32'h0000_0080);
        keyed_wr(`ADDR_LIN_CAL_CONTROL, 32'h0000_0003);
        osc_far_side_i.send_baud(16'h0200);
        @(posedge clock);
        #1 chk("trim lp", 32'h0000_0082, {24'h0, trim.lp});
        rd_chk("lin status mod", `ADDR_LIN_CAL_STATUS, 32'h0000_0005);
        rd_chk("lin status clr", `ADDR_LIN_CAL_STATUS, 32'h0000_0001);
        lp_exp = 8'h82;
        for (int c = 0; c < 4; c++) begin
            keyed_wr(`ADDR_LIN_CAL_CONTROL, (c << 1) | 1);
            osc_far_side_i.send_baud(16'h0010);
            lp_exp = lp_exp - 8'(c + 1);
            @(posedge clock);
            #1 chk("trim lp step", {24'h0, lp_exp}, {24'h0, trim.lp});
        end
        osc_far_side_i.send_baud(16'h00C0);
        @(posedge clock);
        #1 chk("in range", {24'h0, lp_exp}, {24'h0, trim.lp});
        rd_chk("lp current", `ADDR_LP_CURRENT_TRIM, {24'h0, lp_exp});
        rd_chk("lp user", `ADDR_LP_USER_TRIM, 32'h0000_0080);
        // Precision oscillator selected
        bus_wr(`ADDR_LIN_CAL_SELECT, 32'h0000_0000);
        rd_chk("lin status sel", `ADDR_LIN_CAL_STATUS, 32'h0000_0004);
        osc_far_side_i.send_baud(16'h0010);
        @(posedge clock);
        #1 chk("trim prec", 32'h0000_01FC, {22'h0, trim.prec});
        rd_chk("lin status prec", `ADDR_LIN_CAL_STATUS, 32'h0000_0002);
        rd_chk("prec user", `ADDR_PREC_USER_TRIM, 32'h0000_0200);
        // Unkeyed write ignored; copy the precision trim back, then disable
        bus_wr(`ADDR_LIN_CAL_CONTROL, 32'h0000_0000);
        rd_chk("unkeyed", `ADDR_LIN_CAL_CONTROL, 32'h0000_0007);
        keyed_wr(`ADDR_PREC_USER_TRIM, 32'h0000_01FC);
        keyed_wr(`ADDR_LIN_CAL_CONTROL, 32'h0000_0006);
        osc_far_side_i.send_baud(16'h0300);
        @(posedge clock);
        #1 chk("disabled", 32'h0000_01FC, {22'h0, trim.prec});
        rd_chk("lin status off", `ADDR_LIN_CAL_STATUS, 32'h0000_0000);
        $display("Test LIN trimming done");
        report_and_stop();
    end
endmodule
